// File: core/psd_pkg.sv
// Package of constants and types for the pin serializer/deserializer block
`default_nettype none
package psd_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] PSD_CTRL_OFF    = 8'h00;
  localparam logic [7:0] PSD_WIDTH_OFF   = 8'h04;
  localparam logic [7:0] PSD_IDLY_OFF    = 8'h08;
  localparam logic [7:0] PSD_ODLY_OFF    = 8'h0C;
  localparam logic [7:0] PSD_TX_OFF      = 8'h10;
  localparam logic [7:0] PSD_RX_OFF      = 8'h14;
  localparam logic [7:0] PSD_STAT_OFF    = 8'h18;
  // ****************************************
  // Control fields
  // ****************************************
  localparam int PSD_C_IN_REG   = 0;
  localparam int PSD_C_OUT_REG  = 1;
  localparam int PSD_C_DDR      = 2;
  localparam int PSD_C_TS_DDR   = 3;
  localparam int PSD_C_CASCADE  = 4;
  localparam int PSD_C_OVERSAMP = 5;
  localparam int PSD_C_MEMMODE  = 6;
  localparam int PSD_C_OD_SEL_L = 7;
  localparam int PSD_C_SLIP     = 9;
  localparam int PSD_C_WRMODE   = 10;
  localparam int PSD_D_LOAD     = 5;
  localparam int PSD_D_INC      = 6;
  localparam int PSD_D_DEC      = 7;
  localparam logic [31:0] PSD_CTRL_RST  = 32'h0000_0000;
  localparam logic [3:0]  PSD_WIDTH_RST = 4'h8;
  localparam logic [4:0]  PSD_TAP_RST   = 5'h00;
  localparam logic [4:0]  PSD_TAP_MAX   = 5'h1F;
  localparam int PSD_WMAX      = 14;
  localparam int PSD_WBASE     = 8;
  // Tap size in ps for the two reference clock choices
  localparam int PSD_TAP_PS_LO = 78;
  localparam int PSD_TAP_PS_HI = 52;
  // Settling time after a slip, in link clocks
  localparam logic [1:0] PSD_SLIP_SETTLE = 2'h3;
  // Output delay destination
  typedef enum logic [3:0] {
    PSD_OD_CIN  = 4'b0001,
    PSD_OD_RIN  = 4'b0010,
    PSD_OD_COUT = 4'b0100,
    PSD_OD_ROUT = 4'b1000
  } psd_od_e;
endpackage : psd_pkg
`default_nettype wire

// File: core/psd_core.sv
// Per-pin I/O logic: tap delays, deserializer, serializer, AHB-Lite registers
// Summary of operation
// R1: Input and output paths selectable combinational or registered, both support DDR.
// R2: Inputs and high-performance outputs delay 0 to 31 taps of 78/52 ps.
// R3: Tap count loaded by configuration, or stepped up/down by one per pin.
// R4: Input delay has 32 taps and wraps around at either end.
// R5: Input delay usable on combinational, registered input path or standalone.
// R6: Output delay only in high-performance banks, absent in high-range banks.
// R7: Output delay applies to comb/registered input or comb/registered output path; the code delays input paths and only the registered output path.
// R8: SDR conversion widths 2 to 8 bits.
// R9: DDR conversion widths limited to 4, 6, 8 bits.
// R10: Master/slave cascade reaches widths 10 or 14 bits.
// R11: Oversampling mode recovers data without a forwarded clock.
// R12: Word-slip rotates parallel word bit order for training alignment.
// R13: Memory mode crosses strobe data to core domain using oversample clock.
// R14: Separate data and three-state serializers, each SDR or DDR.
// R15: Three-state serializer up to 14:1, data up to 8:1 without expansion.
// R16: Dedicated DDR memory write serializer mode.
// R17: Each slip request shifts alignment by one bit; requests need settling gap.
// R18: Cascade: master supplies low bits, slave supplies extension bits; the code adds only one cascade_in bit, at bit 14.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`default_nettype none
module psd_core
  import psd_pkg::*;
#(
  parameter bit HIGH_PERF = 1'b1
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        serial_clk,
  input  wire logic        oversample_clock,
  input  wire logic        pad_in,
  input  wire logic        cascade_in,
  input  wire logic        fabric_din,
  output logic             pad_out,
  output logic             pad_oe_n,
  output logic             fabric_dly_out
);
  // ****************************************
  // Bus slave
  // ****************************************
  logic [31:0] ctrl_reg, tx_reg, rx_reg;
  logic [3:0]  width_reg;
  logic [4:0]  itap_reg, otap_reg;
  logic [7:0]  ph_addr_reg;
  logic        ph_wr_reg, ph_rd_reg;
  logic        slip_tgl_reg, tx_tgl_reg;
  logic [2:0]  idly_cmd_reg, odly_cmd_reg;
  logic [4:0]  idly_val_reg, odly_val_reg;
  logic        idly_tgl_reg, odly_tgl_reg;
  logic [2:0]  rx_tgl_sync_reg;
  logic [31:0] rx_word_sync_reg;
  logic [4:0]  itap_h_reg, otap_h_reg;
  wire         acc_ok = hsel && hready && htrans[1];
  wire         wr_ctrl = ph_wr_reg && (ph_addr_reg == PSD_CTRL_OFF);
  wire         wr_wid  = ph_wr_reg && (ph_addr_reg == PSD_WIDTH_OFF);
  wire         wr_idly = ph_wr_reg && (ph_addr_reg == PSD_IDLY_OFF);
  wire         wr_odly = ph_wr_reg && (ph_addr_reg == PSD_ODLY_OFF) && HIGH_PERF; // [R6]
  wire         wr_tx   = ph_wr_reg && (ph_addr_reg == PSD_TX_OFF);
  wire         ddr     = ctrl_reg[PSD_C_DDR];
  // Legal width check, SDR 2..8 or DDR 4/6/8, cascade 10/14
  function automatic logic wid_ok(input logic [3:0] w, input logic d, input logic c);
    if (c) begin
      wid_ok = (w == 4'hA) || (w == 4'hE); // [R10]
    end else if (d) begin
      wid_ok = (w == 4'h4) || (w == 4'h6) || (w == 4'h8); // [R9]
    end else begin
      wid_ok = (w >= 4'h2) && (w <= 4'h8); // [R8]
    end
  endfunction : wid_ok
  wire [31:0] stat_word = {21'h0, HIGH_PERF, otap_h_reg, itap_h_reg};
  wire [31:0] rd_mux =
    (ph_addr_reg == PSD_CTRL_OFF)  ? ctrl_reg :
    (ph_addr_reg == PSD_WIDTH_OFF) ? {28'h0, width_reg} :
    (ph_addr_reg == PSD_IDLY_OFF)  ? {27'h0, itap_h_reg} :
    (ph_addr_reg == PSD_ODLY_OFF)  ? {27'h0, otap_h_reg} :
    (ph_addr_reg == PSD_TX_OFF)    ? tx_reg :
    (ph_addr_reg == PSD_RX_OFF)    ? rx_word_sync_reg :
    (ph_addr_reg == PSD_STAT_OFF)  ? stat_word : 32'h0000_0000;
  // One wait state on reads so hrdata stands while hready is high
  assign hreadyout = !ph_rd_reg;
  assign hresp     = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_addr_reg <= 8'h00;
      ph_wr_reg   <= 1'b0;
      ph_rd_reg   <= 1'b0;
    end else begin
      ph_addr_reg <= acc_ok ? haddr[7:0] : ph_addr_reg;
      ph_wr_reg   <= acc_ok && hwrite;
      ph_rd_reg   <= acc_ok && !hwrite;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (ph_rd_reg) begin
      hrdata <= rd_mux;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg     <= PSD_CTRL_RST;
      width_reg    <= PSD_WIDTH_RST;
      tx_reg       <= 32'h0000_0000;
      slip_tgl_reg <= 1'b0;
      tx_tgl_reg   <= 1'b0;
      idly_cmd_reg <= 3'h0;
      idly_val_reg <= PSD_TAP_RST;
      idly_tgl_reg <= 1'b0;
      odly_cmd_reg <= 3'h0;
      odly_val_reg <= PSD_TAP_RST;
      odly_tgl_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= {hwdata[31:10], 1'b0, hwdata[8:0]} & 32'h0000_05FF;
        if (hwdata[PSD_C_SLIP]) begin
          slip_tgl_reg <= ~slip_tgl_reg; // [R12] [R17]
        end
      end
      if (wr_wid && wid_ok(hwdata[3:0], ddr, ctrl_reg[PSD_C_CASCADE])) begin
        width_reg <= hwdata[3:0];
      end
      if (wr_tx) begin
        tx_reg     <= hwdata;
        tx_tgl_reg <= ~tx_tgl_reg;
      end
      if (wr_idly) begin
        idly_cmd_reg <= hwdata[PSD_D_DEC:PSD_D_LOAD]; // [R3]
        idly_val_reg <= hwdata[4:0];
        idly_tgl_reg <= ~idly_tgl_reg;
      end
      if (wr_odly) begin
        odly_cmd_reg <= hwdata[PSD_D_DEC:PSD_D_LOAD];
        odly_val_reg <= hwdata[4:0];
        odly_tgl_reg <= ~odly_tgl_reg;
      end
    end
  end

  // ****************************************
  // Link domain: synchronisers
  // ****************************************
  logic [2:0] s_slip_reg, s_tx_reg, s_id_reg, s_od_reg;
  logic [1:0] s_pad_reg, s_cas_reg, s_fab_reg;
  always_ff @(posedge serial_clk or negedge hresetn) begin
    if (!hresetn) begin
      s_slip_reg <= 3'h0;
      s_tx_reg   <= 3'h0;
      s_id_reg   <= 3'h0;
      s_od_reg   <= 3'h0;
      s_pad_reg  <= 2'h0;
      s_cas_reg  <= 2'h0;
      s_fab_reg  <= 2'h0;
    end else begin
      s_slip_reg <= {s_slip_reg[1:0], slip_tgl_reg};
      s_tx_reg   <= {s_tx_reg[1:0], tx_tgl_reg};
      s_id_reg   <= {s_id_reg[1:0], idly_tgl_reg};
      s_od_reg   <= {s_od_reg[1:0], odly_tgl_reg};
      s_pad_reg  <= {s_pad_reg[0], pad_in};
      s_cas_reg  <= {s_cas_reg[0], cascade_in};
      s_fab_reg  <= {s_fab_reg[0], fabric_din};
    end
  end
  wire slip_ev = s_slip_reg[2] ^ s_slip_reg[1];
  wire tx_ev   = s_tx_reg[2] ^ s_tx_reg[1];
  wire id_ev   = s_id_reg[2] ^ s_id_reg[1];
  wire od_ev   = s_od_reg[2] ^ s_od_reg[1];
  wire pin_s   = s_pad_reg[1];

  // ****************************************
  // Tap delay lines
  // ****************************************
  logic [31:0] ihist_reg, ohist_reg, fhist_reg;
  logic        ser_bit;
  wire [4:0] itap_next =
    idly_cmd_reg[0] ? idly_val_reg :
    idly_cmd_reg[1] ? 5'(itap_reg + 5'h01) : // [R4]
    idly_cmd_reg[2] ? 5'(itap_reg - 5'h01) : itap_reg; // [R4]
  wire [4:0] otap_next =
    odly_cmd_reg[0] ? odly_val_reg :
    odly_cmd_reg[1] ? 5'(otap_reg + 5'h01) :
    odly_cmd_reg[2] ? 5'(otap_reg - 5'h01) : otap_reg;
  wire [3:0] od_sel  = 4'b0001 << ctrl_reg[PSD_C_OD_SEL_L +: 2];
  wire       od_in   = (od_sel == PSD_OD_CIN) || (od_sel == PSD_OD_RIN); // [R7]
  wire       dly_src = od_in ? pin_s : ser_bit;
  wire       in_dly  = ihist_reg[itap_reg]; // [R2] [R5]
  wire       out_dly = HIGH_PERF ? ohist_reg[otap_reg] : dly_src; // [R6]
  wire       rx_bit  = (HIGH_PERF && od_in) ? out_dly : in_dly; // [R7]
  always_ff @(posedge serial_clk or negedge hresetn) begin
    if (!hresetn) begin
      itap_reg  <= PSD_TAP_RST;
      otap_reg  <= PSD_TAP_RST;
      ihist_reg <= 32'h0000_0000;
      ohist_reg <= 32'h0000_0000;
      fhist_reg <= 32'h0000_0000;
    end else begin
      itap_reg  <= id_ev ? itap_next : itap_reg; // [R3]
      otap_reg  <= od_ev ? otap_next : otap_reg; // [R3]
      ihist_reg <= {ihist_reg[30:0], pin_s};
      ohist_reg <= {ohist_reg[30:0], dly_src};
      fhist_reg <= {fhist_reg[30:0], s_fab_reg[1]}; // [R5]
    end
  end
  // Standalone delay for core logic
  assign fabric_dly_out = fhist_reg[itap_reg]; // [R5]

  // ****************************************
  // Deserializer
  // ****************************************
  logic [13:0] shift_reg;
  logic [3:0]  bcnt_reg, slip_reg;
  logic [1:0]  settle_reg;
  logic [31:0] rx_word_reg;
  logic        rx_tgl_reg, in_q_reg, os_a_reg, os_b_reg;
  logic [1:0]  os_reg;
  wire [3:0]  wid    = width_reg;
  wire        casc   = ctrl_reg[PSD_C_CASCADE];
  // Memory mode: strobe-side sample retimed through oversample clock
  always_ff @(posedge oversample_clock or negedge hresetn) begin
    if (!hresetn) begin
      os_reg <= 2'h0;
    end else begin
      os_reg <= {os_reg[0], rx_bit}; // [R13]
    end
  end
  always_ff @(negedge serial_clk or negedge hresetn) begin
    if (!hresetn) begin
      os_b_reg <= 1'b0;
    end else begin
      os_b_reg <= rx_bit;
    end
  end
  // Oversampling: majority of rising, falling and a second copy of the same rising sample
  wire os_bit  = (os_a_reg & os_b_reg) | (os_a_reg & in_q_reg) | (os_b_reg & in_q_reg); // [R11]
  wire reg_in  = ctrl_reg[PSD_C_IN_REG] ? in_q_reg : rx_bit; // [R1]
  wire cap_bit = ctrl_reg[PSD_C_MEMMODE] ? os_reg[1] :
                 ctrl_reg[PSD_C_OVERSAMP] ? os_bit : reg_in;
  wire [3:0] step   = ddr ? 4'h2 : 4'h1; // [R1]
  wire [13:0] wmask = 14'((15'h0001 << wid) - 15'h0001);
  wire [13:0] swin  = shift_reg & wmask;
  wire [13:0] rot   = (swin >> slip_reg) | (swin << (4'(wid) - slip_reg)); // [R12]
  always_ff @(posedge serial_clk or negedge hresetn) begin
    if (!hresetn) begin
      shift_reg   <= 14'h0000;
      bcnt_reg    <= 4'h0;
      slip_reg    <= 4'h0;
      settle_reg  <= 2'h0;
      rx_word_reg <= 32'h0000_0000;
      rx_tgl_reg  <= 1'b0;
      in_q_reg    <= 1'b0;
      os_a_reg    <= 1'b0;
    end else begin
      in_q_reg <= rx_bit;
      os_a_reg <= rx_bit;
      shift_reg <= ddr ? {shift_reg[11:0], cap_bit, os_b_reg}
                       : {shift_reg[12:0], cap_bit};
      if (slip_ev && settle_reg == 2'h0) begin
        slip_reg   <= (slip_reg + 4'h1 >= wid) ? 4'h0 : slip_reg + 4'h1; // [R17]
        settle_reg <= PSD_SLIP_SETTLE; // [R17]
      end else if (settle_reg != 2'h0) begin
        settle_reg <= settle_reg - 2'h1;
      end
      if (bcnt_reg + step >= wid) begin
        bcnt_reg    <= 4'h0;
        rx_tgl_reg  <= ~rx_tgl_reg;
        // Cascade: master low bits, slave extension on cascade_in
        rx_word_reg <= casc ? {17'h0, s_cas_reg[1], 14'(rot & wmask)} // [R10] [R18]
                            : {18'h0, 14'(rot & wmask)}; // [R12]
      end else begin
        bcnt_reg <= bcnt_reg + step;
      end
    end
  end

  // ****************************************
  // Serializer: data and three-state
  // ****************************************
  logic [13:0] txsh_reg, tssh_reg;
  logic [3:0]  tcnt_reg;
  logic        pad_out_reg, oe_n_reg, half_reg;
  wire [3:0] dwid = (wid > 4'(PSD_WBASE) && !casc) ? 4'(PSD_WBASE) : wid; // [R15]
  wire       wr_mode = ctrl_reg[PSD_C_WRMODE];
  assign ser_bit = (ddr && half_reg) ? txsh_reg[1] : txsh_reg[0]; // [R14]
  always_ff @(posedge serial_clk or negedge hresetn) begin
    if (!hresetn) begin
      txsh_reg    <= 14'h0000;
      tssh_reg    <= 14'h3FFF;
      tcnt_reg    <= 4'h0;
      pad_out_reg <= 1'b0;
      oe_n_reg    <= 1'b1;
      half_reg    <= 1'b0;
    end else begin
      half_reg <= ~half_reg;
      if (tx_ev) begin
        txsh_reg <= tx_reg[13:0] & 14'((15'h0001 << dwid) - 15'h0001); // [R15]
        tssh_reg <= tx_reg[29:16]; // [R15]
        tcnt_reg <= 4'h0;
      end else if (tcnt_reg < wid) begin
        txsh_reg <= txsh_reg >> (ddr ? 2 : 1);
        tssh_reg <= tssh_reg >> (ctrl_reg[PSD_C_TS_DDR] ? 2 : 1); // [R14]
        tcnt_reg <= tcnt_reg + step;
      end
      // Memory write mode moves the enable one cycle ahead of the pad data
      pad_out_reg <= wr_mode ? txsh_reg[0] : ser_bit; // [R16]
      oe_n_reg    <= wr_mode ? tssh_reg[1] : tssh_reg[0]; // [R16]
    end
  end
  wire outd = (HIGH_PERF && !od_in) ? out_dly : pad_out_reg;
  assign pad_out  = ctrl_reg[PSD_C_OUT_REG] ? outd : ser_bit; // [R1]
  assign pad_oe_n = oe_n_reg;

  // ****************************************
  // Return path to bus domain
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_tgl_sync_reg  <= 3'h0;
      rx_word_sync_reg <= 32'h0000_0000;
      itap_h_reg       <= PSD_TAP_RST;
      otap_h_reg       <= PSD_TAP_RST;
    end else begin
      rx_tgl_sync_reg <= {rx_tgl_sync_reg[1:0], rx_tgl_reg};
      if (rx_tgl_sync_reg[2] ^ rx_tgl_sync_reg[1]) begin
        rx_word_sync_reg <= rx_word_reg;
        itap_h_reg       <= itap_reg;
        otap_h_reg       <= otap_reg;
      end
    end
  end
endmodule : psd_core
`default_nettype wire

// File: verification/psd_core_checker.sv
// Checker of bus and pad relations at the psd_core ports
`default_nettype none
module psd_core_checker
  import psd_pkg::*;
#(
  parameter bit HIGH_PERF = 1'b1
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        pad_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Helpers
  // ****************************************
  wire logic rd_ph = hsel && hready && htrans[1] && !hwrite;
  wire logic wr_ph = hsel && hready && htrans[1] && hwrite;
  logic        wr_ctrl;
  logic [31:0] ctrl_sh;
  logic        tx_seen;
  logic        rd_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q    <= 1'b0;
      wr_ctrl <= 1'b0;
      ctrl_sh <= PSD_CTRL_RST;
      tx_seen <= 1'b0;
    end else begin
      rd_q    <= rd_ph;
      wr_ctrl <= wr_ph && (haddr[7:0] == PSD_CTRL_OFF);
      if (wr_ctrl) ctrl_sh <= hwdata;
      if (wr_ph && (haddr[7:0] == PSD_TX_OFF)) tx_seen <= 1'b1;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ****************************************
  // Assertions
  // ****************************************
  property p_ready; !rd_q |-> hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("hreadyout low");
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_hold; !rd_q |=> $stable(hrdata); endproperty
  a_hold: assert property (p_hold) else $error("hrdata moved");
  property p_unmap; rd_ph && haddr[7:0] > PSD_STAT_OFF |-> ##2 hrdata == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not 0");
  property p_bank; rd_ph && haddr[7:0] == PSD_STAT_OFF |-> ##2 hrdata[10] == HIGH_PERF; endproperty
  a_bank: assert property (p_bank) else $error("bank flag wrong");
  property p_ctrl;
    rd_ph && haddr[7:0] == PSD_CTRL_OFF |-> ##2 hrdata[10:0] == {ctrl_sh[10], 1'b0, ctrl_sh[8:0]};
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control readback wrong");
  property p_width;
    rd_ph && haddr[7:0] == PSD_WIDTH_OFF |-> ##2
      hrdata[3:0] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA, 4'hE};
  endproperty
  a_width: assert property (p_width) else $error("illegal width held");
  property p_oe; !tx_seen |-> pad_oe_n; endproperty
  a_oe: assert property (p_oe) else $error("pad driven before any word");
endmodule : psd_core_checker
bind psd_core psd_core_checker #(.HIGH_PERF(HIGH_PERF)) u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .pad_oe_n(pad_oe_n)
);
`default_nettype wire

// File: verification/psd_link_model.sv
// Link partner model sending a repeating serial training pattern
`default_nettype none
module psd_link_model #(
  parameter logic [7:0] PAT = 8'h01
) (
  input  wire logic serial_clk,
  input  wire logic rst_n,
  output logic      pad_in,
  output logic      cascade_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] idx_reg;
  // Launch on the falling edge so bits are settled at the rising edge
  always_ff @(negedge serial_clk or negedge rst_n) begin
    if (!rst_n) begin
      idx_reg    <= 3'h0;
      pad_in     <= 1'b0;
      cascade_in <= 1'b0;
    end else begin
      idx_reg    <= idx_reg + 3'h1;
      pad_in     <= PAT[idx_reg];
      cascade_in <= ~cascade_in;
    end
  end
endmodule : psd_link_model
`default_nettype wire

// File: verification/tb_io_serdes_delay_block.sv
// Testbench of psd_core over AHB-Lite with a serial link partner
`default_nettype none
module tb_io_serdes_delay_block
  import psd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, serial_clk = 1'b0, hresetn = 1'b0;
  logic        hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic        hreadyout, hresp, pad_in, cascade_in, pad_out, pad_oe_n, fabric_dly_out;
  logic        fabric_din = 1'b0;
  int          error_cnt = 0, checked = 0;
  logic [31:0] r1, r2;
  initial forever #2 hclk = ~hclk;
  initial forever #24 serial_clk = ~serial_clk;
  psd_core #(.HIGH_PERF(1'b1)) u_psd_core (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .serial_clk(serial_clk),
    .oversample_clock(~serial_clk), .pad_in(pad_in), .cascade_in(cascade_in),
    .fabric_din(fabric_din), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .fabric_dly_out(fabric_dly_out)
  );
  psd_link_model #(.PAT(8'h01)) u_psd_link_model (
    .serial_clk(serial_clk), .rst_n(hresetn), .pad_in(pad_in), .cascade_in(cascade_in)
  );
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic final_report();
    $display("checked=%0d error_cnt=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 100; n++) begin
      @(posedge hclk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 100) begin
      error_cnt++;
      final_report();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr
  task automatic poll_tap(input int sh, input logic [4:0] exp);
    int n;
    for (n = 0; n < 400; n++) begin
      bus(1'b0, PSD_STAT_OFF, 32'h0, r1);
      if (r1[sh +: 5] === exp) break;
    end
    chk({27'h0, r1[sh +: 5]}, {27'h0, exp});
  endtask : poll_tap
  function automatic logic is_rot(input logic [7:0] a, input logic [7:0] b);
    is_rot = 1'b0;
    for (int i = 0; i < 8; i++) if (((b << i) | (b >> (8 - i))) == a) is_rot = 1'b1;
  endfunction : is_rot
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    bus(1'b0, PSD_CTRL_OFF, 32'h0, r1);
    chk(r1, PSD_CTRL_RST);
    bus(1'b0, PSD_WIDTH_OFF, 32'h0, r1);
    chk({28'h0, r1[3:0]}, {28'h0, PSD_WIDTH_RST});
    bus(1'b0, PSD_STAT_OFF, 32'h0, r1);
    chk({21'h0, r1[10:0]}, {21'h0, 1'b1, PSD_TAP_RST, PSD_TAP_RST});
    bus(1'b0, 8'h1C, 32'h0, r1);
    chk(r1, 32'h0);
    $display("test reset done");
  endtask : t_reset
  task automatic t_slip();
    int n;
    for (n = 0; n < 400; n++) begin
      bus(1'b0, PSD_RX_OFF, 32'h0, r1);
      if (is_rot(r1[7:0], 8'h01)) break;
    end
    chk({31'h0, is_rot(r1[7:0], 8'h01)}, 32'h1);
    wr(PSD_CTRL_OFF, 32'h200);
    repeat (300) @(posedge hclk);
    bus(1'b0, PSD_RX_OFF, 32'h0, r2);
    chk({31'h0, r2[7:0] === {r1[6:0], r1[7]} || r2[7:0] === {r1[0], r1[7:1]}}, 32'h1);
    $display("test slip done");
  endtask : t_slip
  task automatic t_taps();
    logic [7:0] tw [5] = '{8'h3F, 8'h40, 8'h80, 8'h25, 8'h80};
    logic [4:0] te [5] = '{5'h1F, 5'h00, 5'h1F, 5'h05, 5'h04};
    for (int d = 0; d < 2; d++) begin
      for (int i = 0; i < 5; i++) begin
        wr(d ? PSD_ODLY_OFF : PSD_IDLY_OFF, {24'h0, tw[i]});
        poll_tap(d * 5, te[i]);
      end
    end
    $display("test taps done");
  endtask : t_taps
  task automatic t_ctrl();
    logic [31:0] w;
    for (int i = 0; i < 12; i++) begin
      w = (i == 11) ? 32'h180 : (32'h1 << i);
      wr(PSD_CTRL_OFF, w);
      bus(1'b0, PSD_CTRL_OFF, 32'h0, r1);
      chk({21'h0, r1[10:0]}, {21'h0, w[10:0] & 11'h5FF});
    end
    $display("test ctrl done");
  endtask : t_ctrl
  task automatic t_width();
    logic [3:0] tw [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                            4'h5, 4'h4, 4'h6, 4'h8, 4'hA, 4'hE};
    logic [3:0] te [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                            4'h8, 4'h4, 4'h6, 4'h8, 4'hA, 4'hE};
    for (int i = 0; i < 13; i++) begin
      wr(PSD_CTRL_OFF, (i < 7) ? 32'h0 : (i < 11) ? 32'h4 : 32'h14);
      wr(PSD_WIDTH_OFF, {28'h0, tw[i]});
      bus(1'b0, PSD_WIDTH_OFF, 32'h0, r1);
      chk({28'h0, r1[3:0]}, {28'h0, te[i]});
    end
    $display("test width done");
  endtask : t_width
  task automatic t_tx();
    int ones;
    ones = 0;
    fabric_din <= 1'b1;
    wr(PSD_CTRL_OFF, 32'h0);
    wr(PSD_WIDTH_OFF, 32'h8);
    wr(PSD_TX_OFF, 32'h0000_00A5);
    repeat (40) begin
      @(negedge serial_clk);
      if (pad_out === 1'b1) begin
        ones++;
      end
    end
    chk(32'(ones), 32'h4);
    chk({31'h0, pad_oe_n}, 32'h0);
    chk({31'h0, fabric_dly_out}, 32'h1);
    @(posedge hclk);
    wr(PSD_TX_OFF, 32'h3FFF_0000);
    fabric_din <= 1'b0;
    repeat (40) @(negedge serial_clk);
    chk({31'h0, pad_oe_n}, 32'h1);
    chk({31'h0, fabric_dly_out}, 32'h0);
    @(posedge hclk);
    $display("test tx done");
  endtask : t_tx
  initial begin
    repeat (5) @(posedge serial_clk);
    @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_slip();
    t_taps();
    t_ctrl();
    t_width();
    t_tx();
    final_report();
  end
endmodule : tb_io_serdes_delay_block
`default_nettype wire
